// ---- ulab_pkg.sv ----
// Shared constants for the LIN auto-baud receive port.
package ulab_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [4:0] OFS_MODE = 5'h00;
  localparam logic [4:0] OFS_STAT = 5'h04;
  localparam logic [4:0] OFS_TXH = 5'h08;
  localparam logic [4:0] OFS_RXH = 5'h0c;
  localparam logic [4:0] OFS_DIV = 5'h10;
  localparam logic [4:0] OFS_IST = 5'h14;
  localparam logic [4:0] OFS_IMSK = 5'h18;
  // ==========================================================
  // Mode register fields
  localparam int MODE_EN = 15;
  localparam int MODE_WAKE = 7;
  localparam int MODE_RATE_ARM = 5;
  localparam int MODE_BRGH = 3;
  localparam logic [15:0] MODE_WMASK = 16'hbbff;
  // ==========================================================
  // Status register fields
  localparam int STAT_TRMT = 8;
  localparam int STAT_RIDLE = 4;
  localparam int STAT_FRAME_ERR = 2;
  localparam int STAT_OERR = 1;
  localparam int STAT_RXDA = 0;
  // ==========================================================
  // Interrupt status bits
  localparam int IRQ_RX = 0;
  localparam int IRQ_FRAME_ERR = 1;
  localparam int IRQ_ABD = 2;
  localparam int IRQ_W = 3;
  // ==========================================================
  // Reset values
  localparam logic [15:0] RST_MODE = 16'h0000;
  localparam logic [15:0] RST_STAT = 16'h0110;
  localparam logic [15:0] RST_RXH = 16'h0000;
  localparam logic [15:0] RST_DIV = 16'h0000;
  // ==========================================================
  // Synch field and measurement
  localparam logic [7:0] SYNCH_VALUE = 8'h55;
  localparam logic [2:0] SYNCH_RISES = 3'h5;
  localparam int SHIFT_LO = 7;
  localparam int SHIFT_HI = 5;
  localparam int OVS_LO = 4;
  localparam int OVS_HI = 2;
  localparam logic [2:0] LAST_BIT = 3'h7;
endpackage : ulab_pkg

// ---- ulab_rx.sv ----
// LIN auto-baud receive port with Avalon-MM register slave.
// ==========================================================
// Functional notes
// RL1: Each received LIN byte goes to receive holding.
// RL2: Wake before measure arm skips break measurement.
// RL3: Break accepted, low stop sets framing error.
// RL4: After bad stop wait for high first.
// RL5: Hardware clears wake arm on valid stop; here it clears when the line goes high after a low stop.
// RL6: Fifth synch rising edge loads measured divisor.
// RL7: Measure arm cleared when divisor loaded.
// RL8: Without wake, delimiter counts as first edge.
// RL9: Software preloads divisor near expected rate.
// RL10: Unimplemented bits read zero; unknowns unreliable.
// RL11: Synch byte is 0x55, alternating transitions.
// RL12: Master sends start, twelve zeros, delimiter.
// RL13: Count clocks edge one to five, scale.
//
// Implementation choices: the Avalon-MM slave port and the address map.
`timescale 1ns/10ps
module ulab_rx (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rx_line,
  output logic irq
);
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_WAITHI} ulab_rx_e;

  // ==========================================================
  // Bus slave
  logic [15:0] mode_r;
  localparam int IRQ_W_LEN = ulab_pkg::IRQ_W;
  logic [15:0] div_r;
  logic [7:0] rxh_r;
  logic rxda_r;
  logic oerr_r;
  logic frame_err_r;
  logic [IRQ_W_LEN-1:0] ist_r;
  logic [IRQ_W_LEN-1:0] imsk_r;
  logic req;
  logic acc;
  logic wr_acc;
  logic rd_acc;
  logic [15:0] wd;
  logic [15:0] rd_nxt;
  ulab_rx_e st_r;

  assign req = avs_read | avs_write;
  assign acc = req & ~avs_waitrequest;
  assign wr_acc = avs_write & ~avs_waitrequest;
  assign rd_acc = avs_read & ~avs_waitrequest;
  assign wd = avs_writedata[15:0];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~(req & avs_waitrequest);
    end
  end

  always_comb begin
    rd_nxt = 16'h0000;
    case (avs_address)
      ulab_pkg::OFS_MODE: rd_nxt = mode_r & ulab_pkg::MODE_WMASK; // [RL10]
      ulab_pkg::OFS_STAT: begin
        rd_nxt[ulab_pkg::STAT_TRMT] = 1'b1;
        rd_nxt[ulab_pkg::STAT_RIDLE] = (st_r == RX_IDLE);
        rd_nxt[ulab_pkg::STAT_FRAME_ERR] = frame_err_r;
        rd_nxt[ulab_pkg::STAT_OERR] = oerr_r;
        rd_nxt[ulab_pkg::STAT_RXDA] = rxda_r;
      end
      ulab_pkg::OFS_RXH: rd_nxt = {8'h00, rxh_r}; // [RL10]
      ulab_pkg::OFS_DIV: rd_nxt = div_r;
      ulab_pkg::OFS_IST: rd_nxt = {13'h0000, ist_r};
      ulab_pkg::OFS_IMSK: rd_nxt = {13'h0000, imsk_r};
      default: rd_nxt = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & avs_waitrequest) begin
      avs_readdata <= {16'h0000, rd_nxt};
    end
  end

  // ==========================================================
  // Line synchroniser
  logic rx_s1;
  logic rx_s2;
  logic rx_d;
  logic rise;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_d <= 1'b1;
    end else begin
      rx_s1 <= rx_line;
      rx_s2 <= rx_s1;
      rx_d <= rx_s2;
    end
  end
  assign rise = rx_s2 & ~rx_d;

  // ==========================================================
  // Rate measurement
  logic ab_run;
  logic [2:0] ab_edges_r;
  logic [23:0] ab_cnt_r;
  logic ab_load;
  logic [23:0] ab_scaled;

  // Measuring is held off while the wake arm waits for the break.
  assign ab_run = mode_r[ulab_pkg::MODE_RATE_ARM] & ~mode_r[ulab_pkg::MODE_WAKE]; // [RL2] [RL8]
  // Edges one to five of the synch byte span eight bit times.
  assign ab_load = ab_run & rise & (ab_edges_r == ulab_pkg::SYNCH_RISES - 3'h1); // [RL6] [RL11]
  assign ab_scaled = mode_r[ulab_pkg::MODE_BRGH] ? (ab_cnt_r >> ulab_pkg::SHIFT_HI)
                                                 : (ab_cnt_r >> ulab_pkg::SHIFT_LO); // [RL13]

  always_ff @(posedge clk_sys) begin
    if (rst || !ab_run) begin
      ab_edges_r <= 3'h0;
      ab_cnt_r <= 24'h000000;
    end else if (rise) begin
      ab_edges_r <= ab_load ? 3'h0 : ab_edges_r + 3'h1; // [RL8]
      // Only edge one restarts the count, otherwise just the last bit pair is measured.
      ab_cnt_r <= (ab_edges_r == 3'h0) ? 24'h000001 : ab_cnt_r + 24'h000001; // [RL13]
    end else if (ab_edges_r != 3'h0) begin
      ab_cnt_r <= ab_cnt_r + 24'h000001; // [RL13]
    end
  end

  // ==========================================================
  // Receiver
  logic [20:0] bit_len;
  logic [20:0] cnt_r;
  logic [2:0] nbit_r;
  logic [7:0] sh_r;
  logic got_byte;
  logic bad_stop;
  logic wake_clr;

  assign bit_len = mode_r[ulab_pkg::MODE_BRGH]
    ? ({5'h00, div_r} + 21'h000001) << ulab_pkg::OVS_HI
    : ({5'h00, div_r} + 21'h000001) << ulab_pkg::OVS_LO;
  assign got_byte = (st_r == RX_STOP) && (cnt_r == 21'h000000); // [RL1] [RL3]
  assign bad_stop = got_byte & ~rx_s2; // [RL3]
  assign wake_clr = (st_r == RX_WAITHI) & rx_s2 & mode_r[ulab_pkg::MODE_WAKE]; // [RL5]

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= RX_IDLE;
      cnt_r <= 21'h000000;
      nbit_r <= 3'h0;
      sh_r <= 8'h00;
    end else begin
      cnt_r <= (cnt_r == 21'h000000) ? 21'h000000 : cnt_r - 21'h000001;
      case (st_r)
        RX_IDLE: begin
          if (!rx_s2 && mode_r[ulab_pkg::MODE_EN] && !ab_run) begin
            st_r <= RX_START;
            // Loads are one short because the zero cycle itself ends the span.
            cnt_r <= (bit_len >> 1) - 21'h000001;
          end
        end
        RX_START: begin
          if (cnt_r == 21'h000000) begin
            st_r <= rx_s2 ? RX_IDLE : RX_DATA;
            cnt_r <= bit_len - 21'h000001;
            nbit_r <= 3'h0;
          end
        end
        RX_DATA: begin
          if (cnt_r == 21'h000000) begin
            sh_r <= {rx_s2, sh_r[7:1]};
            nbit_r <= nbit_r + 3'h1;
            cnt_r <= bit_len - 21'h000001;
            if (nbit_r == ulab_pkg::LAST_BIT) begin
              st_r <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (cnt_r == 21'h000000) begin
            st_r <= rx_s2 ? RX_IDLE : RX_WAITHI; // [RL4]
          end
        end
        RX_WAITHI: begin
          if (rx_s2) begin
            st_r <= RX_IDLE; // [RL4]
          end
        end
        default: st_r <= RX_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Registers written by software and hardware
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_r <= ulab_pkg::RST_MODE;
    end else begin
      if (wr_acc && avs_address == ulab_pkg::OFS_MODE && avs_byteenable[1:0] == 2'b11) begin
        mode_r <= wd & ulab_pkg::MODE_WMASK;
      end
      // Hardware clears win over a simultaneous software write.
      if (wake_clr) begin
        mode_r[ulab_pkg::MODE_WAKE] <= 1'b0; // [RL5]
      end
      if (ab_load) begin
        mode_r[ulab_pkg::MODE_RATE_ARM] <= 1'b0; // [RL7]
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_r <= ulab_pkg::RST_DIV;
    end else if (ab_load) begin
      div_r <= ab_scaled[15:0] - 16'h0001; // [RL6] [RL7]
    end else if (wr_acc && avs_address == ulab_pkg::OFS_DIV && avs_byteenable[1:0] == 2'b11) begin
      div_r <= wd; // [RL9]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxh_r <= ulab_pkg::RST_RXH[7:0];
      rxda_r <= 1'b0;
      oerr_r <= 1'b0;
      frame_err_r <= 1'b0;
    end else begin
      if (rd_acc && avs_address == ulab_pkg::OFS_RXH) begin
        rxda_r <= 1'b0;
      end
      if (wr_acc && avs_address == ulab_pkg::OFS_STAT && !wd[ulab_pkg::STAT_OERR]) begin
        oerr_r <= 1'b0;
      end
      if (got_byte) begin
        rxh_r <= sh_r; // [RL1]
        rxda_r <= 1'b1;
        frame_err_r <= bad_stop; // [RL3]
        if (rxda_r) begin
          oerr_r <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Interrupts
  logic [IRQ_W_LEN-1:0] ev;
  assign ev = {ab_load, bad_stop, got_byte};

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ist_r <= '0;
      imsk_r <= '0;
      irq <= 1'b0;
    end else begin
      // A new event wins over a write-one clear in the same cycle.
      if (wr_acc && avs_address == ulab_pkg::OFS_IST) begin
        ist_r <= (ist_r & ~wd[IRQ_W_LEN-1:0]) | ev;
      end else begin
        ist_r <= ist_r | ev;
      end
      if (wr_acc && avs_address == ulab_pkg::OFS_IMSK) begin
        imsk_r <= wd[IRQ_W_LEN-1:0];
      end
      irq <= |(ist_r & imsk_r);
    end
  end

  // ==========================================================
  // Checks
  a_break_frame_err: assert property (@(posedge clk_sys) disable iff (rst) // [RL3]
    bad_stop |=> frame_err_r && st_r == RX_WAITHI)
    else $error("break did not set framing error");
  a_wait_high: assert property (@(posedge clk_sys) disable iff (rst) // [RL4]
    st_r == RX_WAITHI && !rx_s2 |=> st_r == RX_WAITHI) else $error("left wait before high");
  a_wake_clear: assert property (@(posedge clk_sys) disable iff (rst) // [RL5]
    wake_clr |=> !mode_r[ulab_pkg::MODE_WAKE]) else $error("wake arm not cleared");
  a_div_load: assert property (@(posedge clk_sys) disable iff (rst) // [RL6]
    ab_load |=> div_r == $past(ab_scaled[15:0]) - 16'h0001) else $error("divisor not loaded");
  a_rate_arm_clear: assert property (@(posedge clk_sys) disable iff (rst) // [RL7]
    $fell(mode_r[ulab_pkg::MODE_RATE_ARM]) && !$past(wr_acc) |-> $past(ab_load))
    else $error("measure arm cleared without load");
  a_wake_blocks: assert property (@(posedge clk_sys) disable iff (rst) // [RL2]
    mode_r[ulab_pkg::MODE_WAKE] |-> ab_edges_r == 3'h0) else $error("measured during break");
  a_rx_byte: assert property (@(posedge clk_sys) disable iff (rst) // [RL1]
    got_byte |=> rxda_r && rxh_r == $past(sh_r)) else $error("byte not stored");
  a_zero_read: assert property (@(posedge clk_sys) disable iff (rst) // [RL10]
    avs_read && !avs_waitrequest && avs_address == ulab_pkg::OFS_RXH |-> avs_readdata[31:8] == 24'h0)
    else $error("unimplemented bits not zero");
  a_bus_answer: assert property (@(posedge clk_sys) disable iff (rst)
    req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer late");
  a_irq_level: assert property (@(posedge clk_sys) disable iff (rst)
    |(ist_r & imsk_r) |=> irq) else $error("interrupt not raised");
endmodule : ulab_rx

// ---- ulab_lin_node.sv ----
// LIN master node model that drives the serial receive line.
`timescale 1ns/10ps
module ulab_lin_node (
  input wire logic clk_sys,
  output logic rx_line
);
  initial rx_line = 1'b1;
  task automatic hold(input logic lvl, input int n);
    rx_line <= lvl;
    repeat (n) @(posedge clk_sys);
  endtask : hold
  // Start bit, data LSB first, one stop bit.
  task automatic send_byte(input logic [7:0] b, input int bt);
    hold(1'b0, bt);
    for (int i = 0; i < 8; i++) hold(b[i], bt);
    hold(1'b1, bt);
  endtask : send_byte
  // The line rests high afterwards, so the caller sets the delimiter length.
  task automatic send_break(input int bt);
    hold(1'b0, 13 * bt);
    rx_line <= 1'b1;
  endtask : send_break
endmodule : ulab_lin_node

// ---- tb_top.sv ----
// Self-checking bench for the LIN auto-baud receive port.
`timescale 1ns/10ps
module tb_top;
  localparam int BT = 100;
  // Bits run a little long so truncation of the count cannot slip a step.
  localparam int DIV_OK = 8 * BT / 128 - 1;
  // A four-bit delimiter adds three bits to the eight measured ones.
  localparam int DIV_BAD = 11 * BT / 128 - 1;
  typedef struct {
    logic wr;
    logic [4:0] a;
    logic [15:0] d;
    logic [15:0] e;
  } ulab_row_s;
  logic clk_sys;
  logic rst;
  logic [4:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic rx_line;
  logic irq;
  logic [15:0] q;
  int n_mismatch;
  int tests_run;
  int cycles;
  ulab_row_s rows [8] = '{
    '{1'b0, ulab_pkg::OFS_MODE, 16'h0000, ulab_pkg::RST_MODE},
    '{1'b0, ulab_pkg::OFS_STAT, 16'h0000, ulab_pkg::RST_STAT},
    '{1'b0, ulab_pkg::OFS_RXH, 16'h0000, ulab_pkg::RST_RXH},
    '{1'b0, ulab_pkg::OFS_DIV, 16'h0000, ulab_pkg::RST_DIV},
    '{1'b0, 5'h1c, 16'h0000, 16'h0000},
    '{1'b1, ulab_pkg::OFS_MODE, 16'h4400, 16'h0000},
    '{1'b1, ulab_pkg::OFS_TXH, 16'h00ff, 16'h0000},
    '{1'b1, ulab_pkg::OFS_DIV, 16'h1234, 16'h1234}
  };
  ulab_rx u_dut (
    .clk_sys(clk_sys),
    .rst(rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .rx_line(rx_line),
    .irq(irq)
  );
  ulab_lin_node u_node (
    .clk_sys(clk_sys),
    .rx_line(rx_line)
  );
  // ==========================================================
  // Tasks.
  task automatic test_done;
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {16'h0000, d};
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    q = avs_readdata[15:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask : bus
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      test_done();
    end
  end
  // ==========================================================
  // Main sequence.
  initial begin
    rst = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hf;
    n_mismatch = 0;
    tests_run = 0;
    cycles = 0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    foreach (rows[i]) begin
      if (rows[i].wr) bus(1'b1, rows[i].a, rows[i].d);
      bus(1'b0, rows[i].a, 16'h0000);
      chk(q, rows[i].e);
    end
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    bus(1'b0, ulab_pkg::OFS_DIV, 16'h0000);
    chk(q, ulab_pkg::RST_DIV);
    // A divisor write without both low byte lanes must be ignored.
    avs_byteenable <= 4'h0;
    bus(1'b1, ulab_pkg::OFS_DIV, 16'h1234);
    avs_byteenable <= 4'hf;
    bus(1'b0, ulab_pkg::OFS_DIV, 16'h0000);
    chk(q, ulab_pkg::RST_DIV);
    bus(1'b1, ulab_pkg::OFS_DIV, 16'(DIV_OK));
    bus(1'b1, ulab_pkg::OFS_IMSK, 16'h0007);
    bus(1'b1, ulab_pkg::OFS_MODE, 16'h8080);
    bus(1'b1, ulab_pkg::OFS_MODE, 16'h80a0);
    u_node.send_break(BT);
    repeat (BT) @(posedge clk_sys);
    bus(1'b0, ulab_pkg::OFS_STAT, 16'h0000);
    chk(q & 16'h0005, 16'h0005);
    bus(1'b0, ulab_pkg::OFS_RXH, 16'h0000);
    chk(q, 16'h0000);
    bus(1'b0, ulab_pkg::OFS_MODE, 16'h0000);
    chk(q, 16'h8020);
    u_node.send_byte(ulab_pkg::SYNCH_VALUE, BT);
    repeat (10 * BT) @(posedge clk_sys);
    bus(1'b0, ulab_pkg::OFS_MODE, 16'h0000);
    chk(q, 16'h8000);
    bus(1'b0, ulab_pkg::OFS_DIV, 16'h0000);
    chk(q, 16'(DIV_OK));
    bus(1'b0, ulab_pkg::OFS_IST, 16'h0000);
    chk(q & 16'h0006, 16'h0006);
    chk({15'h0000, irq}, 16'h0001);
    bus(1'b0, ulab_pkg::OFS_RXH, 16'h0000);
    bus(1'b1, ulab_pkg::OFS_IST, 16'h0007);
    bus(1'b1, ulab_pkg::OFS_IMSK, 16'h0000);
    repeat (2) @(posedge clk_sys);
    chk({15'h0000, irq}, 16'h0000);
    // A long low line must give one bad byte, then nothing until it goes high.
    u_node.hold(1'b0, 12 * BT);
    bus(1'b0, ulab_pkg::OFS_STAT, 16'h0000);
    chk(q & 16'h0005, 16'h0005);
    chk({15'h0000, irq}, 16'h0000);
    bus(1'b0, ulab_pkg::OFS_RXH, 16'h0000);
    u_node.hold(1'b0, 12 * BT);
    bus(1'b0, ulab_pkg::OFS_STAT, 16'h0000);
    chk(q & 16'h0001, 16'h0000);
    bus(1'b1, ulab_pkg::OFS_IMSK, 16'h0002);
    repeat (2) @(posedge clk_sys);
    chk({15'h0000, irq}, 16'h0001);
    u_node.hold(1'b1, 2 * BT);
    // High speed mode gives four clocks per divisor step.
    bus(1'b1, ulab_pkg::OFS_MODE, 16'h8008);
    u_node.send_byte(8'ha5, 4 * (DIV_OK + 1));
    repeat (BT) @(posedge clk_sys);
    bus(1'b0, ulab_pkg::OFS_STAT, 16'h0000);
    chk(q & 16'h0005, 16'h0001);
    bus(1'b0, ulab_pkg::OFS_RXH, 16'h0000);
    chk(q, 16'h00a5);
    bus(1'b1, ulab_pkg::OFS_MODE, 16'h8020);
    u_node.send_break(BT);
    repeat (4 * BT) @(posedge clk_sys);
    u_node.send_byte(ulab_pkg::SYNCH_VALUE, BT);
    bus(1'b0, ulab_pkg::OFS_DIV, 16'h0000);
    chk(q, 16'(DIV_BAD));
    test_done();
  end
endmodule : tb_top
